// ### logic/sptr_defs.svh
/*
 Offsets, reset values and field positions for the stack and data pointer registers.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SPTR_DEFS_SVH
`define SPTR_DEFS_SVH
`define SPTR_SFR_BASE 8'h80
`define SPTR_ADDR_MSB 7
`define SPTR_STACK_TOP_OFS 8'h81
`define SPTR_DP_LOW_OFS 8'h82
`define SPTR_DP_HIGH_OFS 8'h83
`define SPTR_STACK_TOP_RST 8'h07
`define SPTR_DP_LOW_RST 8'h00
`define SPTR_DP_HIGH_RST 8'h00
`endif

// ### logic/sptr_pkg.sv
/*
 Types shared by the pointer register block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sptr_pkg;
   typedef enum logic [1:0] {STACK_IDLE, STACK_PUSH, STACK_POP} stack_op_t;
   typedef logic [7:0] byte_t;
endpackage

// ### logic/stack_step.sv
/*
 Stack pointer step unit: next pointer and the access address for a push or pop.
 Assumes the caller qualifies the operation code.
*/
`timescale 1ns/1ps
module stack_step (
   input wire logic [7:0] pointer_i,
   input wire sptr_pkg::stack_op_t op_i,
   output logic [7:0] next_pointer_o,
   output logic [7:0] access_addr_o
);
   always_comb begin
      case (op_i)
         sptr_pkg::STACK_PUSH: begin
            next_pointer_o = pointer_i + 8'h01;
            access_addr_o = pointer_i + 8'h01;
         end
         sptr_pkg::STACK_POP: begin
            next_pointer_o = pointer_i - 8'h01;
            access_addr_o = pointer_i;
         end
         default: begin
            next_pointer_o = pointer_i;
            access_addr_o = pointer_i;
         end
      endcase
   end
endmodule

// ### logic/stack_and_data_pointer_regs.sv
/*
 Stack top pointer and 16-bit data pointer registers, reached by direct
 special function register accesses in the upper half of the data space.
 Assumes the core execution logic issues at most one access per cycle and
 that stack and direct writes never coincide (stack wins if they do).
*/
`timescale 1ns/1ps
`include "sptr_defs.svh"
module stack_and_data_pointer_regs (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic direct_valid_i,
   input wire logic direct_write_i,
   input wire logic [7:0] direct_addr_i,
   input wire logic [7:0] direct_wdata_i,
   output logic sfr_select_o,
   output logic reg_hit_o,
   output logic [7:0] direct_rdata_o,
   input wire logic push_i,
   input wire logic pop_i,
   output logic stack_access_o,
   output logic [7:0] stack_addr_o,
   output logic [7:0] stack_top_pointer_o,
   output logic [15:0] data_pointer_o
);
   logic [7:0] stack_top_pointer;
   logic [7:0] data_pointer_low_byte;
   logic [7:0] data_pointer_high_byte;
   logic [7:0] next_stack_top_pointer;
   logic [7:0] next_data_pointer_low_byte;
   logic [7:0] next_data_pointer_high_byte;
   logic [7:0] next_direct_rdata;
   logic [7:0] step_pointer;
   logic [7:0] step_addr;
   sptr_pkg::stack_op_t op;
   logic is_sfr;
   logic wr;

   // Upper half of direct space is the register space
   function automatic logic sfr_space(input logic [7:0] a);
      sfr_space = a[`SPTR_ADDR_MSB];
   endfunction

   assign is_sfr = direct_valid_i && sfr_space(direct_addr_i);
   assign sfr_select_o = is_sfr;
   assign reg_hit_o = is_sfr && (direct_addr_i == `SPTR_STACK_TOP_OFS || direct_addr_i == `SPTR_DP_LOW_OFS ||
                                 direct_addr_i == `SPTR_DP_HIGH_OFS);
   assign wr = is_sfr && direct_write_i;

   // Push takes precedence over pop when both are raised
   assign op = push_i ? sptr_pkg::STACK_PUSH : (pop_i ? sptr_pkg::STACK_POP : sptr_pkg::STACK_IDLE);
   assign stack_access_o = push_i || pop_i;

   stack_step u_step (
      .pointer_i(stack_top_pointer),
      .op_i(op),
      .next_pointer_o(step_pointer),
      .access_addr_o(step_addr)
   );

   // Stack address is combinational so the memory write sees the already incremented slot
   assign stack_addr_o = step_addr;

   always_comb begin
      next_stack_top_pointer = stack_top_pointer;
      next_data_pointer_low_byte = data_pointer_low_byte;
      next_data_pointer_high_byte = data_pointer_high_byte;
      next_direct_rdata = 8'h00;
      if (wr && direct_addr_i == `SPTR_STACK_TOP_OFS) begin
         next_stack_top_pointer = direct_wdata_i;
      end
      if (wr && direct_addr_i == `SPTR_DP_LOW_OFS) begin
         next_data_pointer_low_byte = direct_wdata_i;
      end
      if (wr && direct_addr_i == `SPTR_DP_HIGH_OFS) begin
         next_data_pointer_high_byte = direct_wdata_i;
      end
      if (op != sptr_pkg::STACK_IDLE) begin
         next_stack_top_pointer = step_pointer;
      end
      if (is_sfr && !direct_write_i) begin
         case (direct_addr_i)
            `SPTR_STACK_TOP_OFS: next_direct_rdata = stack_top_pointer;
            `SPTR_DP_LOW_OFS: next_direct_rdata = data_pointer_low_byte;
            `SPTR_DP_HIGH_OFS: next_direct_rdata = data_pointer_high_byte;
            default: next_direct_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stack_top_pointer <= `SPTR_STACK_TOP_RST;
         data_pointer_low_byte <= `SPTR_DP_LOW_RST;
         data_pointer_high_byte <= `SPTR_DP_HIGH_RST;
         direct_rdata_o <= 8'h00;
      end else begin
         stack_top_pointer <= next_stack_top_pointer;
         data_pointer_low_byte <= next_data_pointer_low_byte;
         data_pointer_high_byte <= next_data_pointer_high_byte;
         direct_rdata_o <= next_direct_rdata;
      end
   end

   assign stack_top_pointer_o = stack_top_pointer;
   assign data_pointer_o = {data_pointer_high_byte, data_pointer_low_byte};

   property p_reset_value;
      @(posedge clk_i) $rose(reset_n_i) |-> stack_top_pointer_o == 8'h07;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("stack pointer not 0x07 after reset");

   property p_push_inc;
      @(posedge clk_i) disable iff (!reset_n_i)
         push_i |-> stack_addr_o == stack_top_pointer_o + 8'h01 ##1 stack_top_pointer_o == $past(stack_addr_o);
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push did not pre-increment");

   property p_push_slot;
      @(posedge clk_i) disable iff (!reset_n_i)
         push_i |=> stack_top_pointer_o == $past(stack_addr_o);
   endproperty
   a_push_slot: assert property (p_push_slot) else $error("pointer does not name pushed slot");

   property p_pop_dec;
      @(posedge clk_i) disable iff (!reset_n_i)
         (pop_i && !push_i) |-> stack_addr_o == stack_top_pointer_o ##1 stack_top_pointer_o == $past(stack_addr_o) - 8'h01;
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop did not read then decrement");

   property p_dp_low;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && direct_write_i && direct_addr_i == 8'h82) |=> data_pointer_o[7:0] == $past(direct_wdata_i);
   endproperty
   a_dp_low: assert property (p_dp_low) else $error("low byte write not on bits 7..0");

   property p_dp_high;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && direct_write_i && direct_addr_i == 8'h83) |=> data_pointer_o[15:8] == $past(direct_wdata_i);
   endproperty
   a_dp_high: assert property (p_dp_high) else $error("high byte write not on bits 15..8");

   property p_sfr_decode;
      @(posedge clk_i) disable iff (!reset_n_i)
         sfr_select_o == (direct_valid_i && direct_addr_i >= 8'h80);
   endproperty
   a_sfr_decode: assert property (p_sfr_decode) else $error("register space decode wrong");

   property p_sp_write;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && direct_write_i && direct_addr_i == 8'h81 && !push_i && !pop_i)
            |=> stack_top_pointer_o == $past(direct_wdata_i);
   endproperty
   a_sp_write: assert property (p_sp_write) else $error("stack pointer write lost");

   property p_dp_hold;
      @(posedge clk_i) disable iff (!reset_n_i)
         !(direct_valid_i && direct_write_i) |=> $stable(data_pointer_o);
   endproperty
   a_dp_hold: assert property (p_dp_hold) else $error("data pointer changed without write");

   property p_reset_dp;
      @(posedge clk_i) $rose(reset_n_i) |-> data_pointer_o == 16'h0000;
   endproperty
   a_reset_dp: assert property (p_reset_dp) else $error("data pointer not zero after reset");

   // Read data lags the request by one cycle, so compare against the pointer seen at the request
   property p_rdata_sp;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && !direct_write_i && direct_addr_i == `SPTR_STACK_TOP_OFS)
            |=> direct_rdata_o == $past(stack_top_pointer_o);
   endproperty
   a_rdata_sp: assert property (p_rdata_sp) else $error("stack pointer read wrong");

   property p_rdata_dpl;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && !direct_write_i && direct_addr_i == `SPTR_DP_LOW_OFS)
            |=> direct_rdata_o == $past(data_pointer_o[7:0]);
   endproperty
   a_rdata_dpl: assert property (p_rdata_dpl) else $error("low byte read wrong");

   property p_rdata_dph;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && !direct_write_i && direct_addr_i == `SPTR_DP_HIGH_OFS)
            |=> direct_rdata_o == $past(data_pointer_o[15:8]);
   endproperty
   a_rdata_dph: assert property (p_rdata_dph) else $error("high byte read wrong");

   property p_low_space_hold;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && direct_write_i && !direct_addr_i[7] && !push_i && !pop_i)
            |=> $stable(stack_top_pointer_o) && $stable(data_pointer_o);
   endproperty
   a_low_space_hold: assert property (p_low_space_hold) else $error("RAM write reached a register");

   property p_low_space_rdata;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && !direct_addr_i[7]) |=> direct_rdata_o == 8'h00;
   endproperty
   a_low_space_rdata: assert property (p_low_space_rdata) else $error("RAM access drove read data");

   property p_unmapped_read;
      @(posedge clk_i) disable iff (!reset_n_i)
         (direct_valid_i && !direct_write_i && direct_addr_i[7] && !reg_hit_o) |=> direct_rdata_o == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_reg_hit;
      @(posedge clk_i) disable iff (!reset_n_i)
         reg_hit_o == (sfr_select_o && direct_addr_i[7:2] == 6'h20 && direct_addr_i[1:0] != 2'h0);
   endproperty
   a_reg_hit: assert property (p_reg_hit) else $error("register hit decode wrong");

   property p_sp_hold;
      @(posedge clk_i) disable iff (!reset_n_i)
         (!push_i && !pop_i && !(direct_valid_i && direct_write_i && direct_addr_i == `SPTR_STACK_TOP_OFS))
            |=> $stable(stack_top_pointer_o);
   endproperty
   a_sp_hold: assert property (p_sp_hold) else $error("stack pointer moved without cause");

   property p_idle_addr;
      @(posedge clk_i) disable iff (!reset_n_i)
         (!push_i && !pop_i) |-> stack_addr_o == stack_top_pointer_o;
   endproperty
   a_idle_addr: assert property (p_idle_addr) else $error("idle stack address not the top");
endmodule

// ### tb/stack_ram_model.sv
/*
 Stack RAM seen by the core execution logic: stores pushed bytes, returns popped ones.
 Assumes push and pop never come in the same cycle from the bench.
*/
`timescale 1ns/1ps
module stack_ram_model (
   input wire logic clk_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [7:0] stack_addr_i,
   input wire logic [7:0] push_data_i,
   output logic [7:0] pop_data_o
);
   logic [7:0] mem [256];
   // Byte lands at the address presented with the push
   always_ff @(posedge clk_i) begin
      if (push_i) begin
         mem[stack_addr_i] <= push_data_i;
      end
   end
   // Idle shows the inverse address so stale data never passes
   assign pop_data_o = pop_i ? mem[stack_addr_i] : ~stack_addr_i;
endmodule

// ### tb/test_stack_and_data_pointer_regs.sv
/*
 Testbench for the pointer registers: direct accesses, push and pop, reset.
 Assumes the stack RAM model above.
*/
`timescale 1ns/1ps
module test_stack_and_data_pointer_regs;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic dv = 1'b0, dw = 1'b0, push = 1'b0, pop = 1'b0;
   logic [7:0] da = 8'h00, dd = 8'h00, pd = 8'h00;
   logic sel, hit, sacc;
   logic [7:0] rdata, saddr, sp, popd;
   logic [15:0] dp;
   int error_cnt = 0;
   int n_compared = 0;
   always #20 clk_i = ~clk_i;
   stack_and_data_pointer_regs dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .direct_valid_i(dv),
      .direct_write_i(dw), .direct_addr_i(da), .direct_wdata_i(dd), .sfr_select_o(sel),
      .reg_hit_o(hit), .direct_rdata_o(rdata), .push_i(push), .pop_i(pop), .stack_access_o(sacc),
      .stack_addr_o(saddr), .stack_top_pointer_o(sp), .data_pointer_o(dp));
   stack_ram_model ram (.clk_i(clk_i), .push_i(push), .pop_i(pop), .stack_addr_i(saddr),
      .push_data_i(pd), .pop_data_o(popd));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Pointer registers are full bytes, so no write data can set a reserved bit
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      dv <= 1'b1;
      dw <= w;
      da <= a;
      dd <= d;
      #1 chk({sel, hit}, {a[7], a >= 8'h81 && a <= 8'h83});
      @(posedge clk_i);
      dv <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rdata, exp);
   endtask
   // Pop checks the returned byte; push checks the pre-incremented address
   task automatic stk(input logic is_push, input logic [7:0] d, input logic [7:0] ea, input logic [7:0] esp);
      @(posedge clk_i);
      push <= is_push;
      pop <= !is_push;
      pd <= d;
      #1 chk({sacc, saddr}, {1'b1, ea});
      if (!is_push) chk(popd, d);
      @(posedge clk_i);
      push <= 1'b0;
      pop <= 1'b0;
      #1 chk(sp, esp);
      chk({sacc, saddr}, {1'b0, esp});
   endtask
   task automatic give_verdict;
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(8'h81, 8'h07);
      rd(8'h83, 8'h00);
      acc(1'b1, 8'h82, 8'h34);
      acc(1'b1, 8'h83, 8'h12);
      chk(dp, 16'h1234);
      acc(1'b1, 8'h82, 8'hff);
      chk(dp, 16'h12ff);
      rd(8'h82, 8'hff);
      acc(1'b1, 8'h01, 8'h55);
      acc(1'b1, 8'h84, 8'h66);
      chk(sp, 8'h07);
      rd(8'h84, 8'h00);
      rd(8'h01, 8'h00);
      stk(1'b1, 8'h3c, 8'h08, 8'h08);
      stk(1'b0, 8'h3c, 8'h08, 8'h07);
      acc(1'b1, 8'h81, 8'hfe);
      stk(1'b1, 8'ha1, 8'hff, 8'hff);
      stk(1'b1, 8'hb2, 8'h00, 8'h00);
      stk(1'b0, 8'hb2, 8'h00, 8'hff);
      stk(1'b0, 8'ha1, 8'hff, 8'hfe);
      // Second reset mid-run must restore both pointers
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      @(posedge clk_i);
      #1 chk(sp, 8'h07);
      chk(dp, 16'h0000);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(8'h81, 8'h07);
      rd(8'h82, 8'h00);
      chk(dp, 16'h0000);
      give_verdict;
   end
endmodule
